// ### src/bk1_config.sv
// bk1_config: buck 1 wake/sleep configuration registers and the
// per-timeslot enable / sleep-transition decode for the power sequencer.
// assumes an AXI4-Lite master on the system clock, a sequencer that gives
// a one-hot timeslot strobe, and a boot loader that pulses boot_load.
`timescale 1ns/1ps

module bk1_config (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [17:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [17:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // boot configuration store load
  input  wire logic        boot_load,
  input  wire logic [4:0]  boot_wake_vcode_hi,
  // power-state sequencer
  input  wire logic [4:0]  timeslot_strobe,
  input  wire logic        sleep_state,
  input  wire logic        hw_enable1,
  input  wire logic        hw_enable2,
  // converter control
  output logic             buck1_enable,
  output logic             buck1_sleep_applied,
  output logic [1:0]       buck1_opmode,
  output logic [6:0]       buck1_vcode,
  output logic [14:0]      buck1_vout_100uv,
  output logic             buck1_hw_controlled
);

  // register fields and their next values
  logic [2:0] buck1_wake_slot,    next_wake_slot;
  logic [1:0] buck1_wake_opmode,  next_wake_opmode;
  logic [4:0] wake_vcode_hi,      next_wake_vcode_hi;
  logic [1:0] wake_vcode_lo,      next_wake_vcode_lo;
  logic [2:0] buck1_sleep_slot,   next_sleep_slot;
  logic [1:0] buck1_sleep_opmode, next_sleep_opmode;
  logic [6:0] buck1_sleep_vcode,  next_sleep_vcode;
  logic [6:0] buck1_wake_vcode;

  // bus slave state and its next values
  logic        aw_held,  next_aw_held;
  logic        w_held,   next_w_held;
  logic [17:0] aw_addr,  next_aw_addr;
  logic [31:0] w_data,   next_w_data;
  logic [3:0]  w_strb,   next_w_strb;
  logic        bvalid,   next_bvalid;
  logic [1:0]  bresp,    next_bresp;
  logic        rvalid,   next_rvalid;
  logic [31:0] rdata,    next_rdata;
  logic [1:0]  rresp,    next_rresp;
  logic        do_write, wr_wake, wr_sleep;
  logic [15:0] wake_word, sleep_word;

  // converter state
  typedef enum logic [1:0] {
    bk1_off,
    bk1_on,
    bk1_on_sleep
  } bk1_state_t;
  bk1_state_t state, next_state;

  // slot decode helpers
  logic       wake_hit;
  logic       sleep_hit;
  logic       sleep_is_disable;
  logic       hw_level;
  logic [2:0] sleep_ts;
  logic [6:0] eff_vcode;
  logic [6:0] vlevel;
  logic [1:0] next_opmode;
  logic [14:0] next_vout;
  logic [21:0] vout_wide;

  assign buck1_wake_vcode = {wake_vcode_hi, wake_vcode_lo};
  assign wake_word  = {buck1_wake_slot, 3'h0, buck1_wake_opmode, 1'h0, buck1_wake_vcode};
  assign sleep_word = {buck1_sleep_slot, 3'h0, buck1_sleep_opmode, 1'h0, buck1_sleep_vcode};

  // handshake outputs; a held channel waits for its partner, and both stall
  // while a response is pending so only one write is ever in flight
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  // write path: address and data taken in either order
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wr_wake || wr_sleep) ? bk1_pkg::RESP_OKAY : bk1_pkg::RESP_SLVERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // commit one cycle after both halves are held
  assign do_write = aw_held && w_held && !bvalid;
  assign wr_wake  = do_write && (aw_addr[17:2] == bk1_pkg::IDX_WAKE_CONFIG);
  assign wr_sleep = do_write && (aw_addr[17:2] == bk1_pkg::IDX_SLEEP_CONFIG);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 18'h00000;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= 2'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
    end
  end

  // read path: data registered, one cycle after the address is taken
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = bk1_pkg::RESP_OKAY;
      if (s_axi_araddr[17:2] == bk1_pkg::IDX_WAKE_CONFIG) begin
        next_rdata = {16'h0000, wake_word};
      end else if (s_axi_araddr[17:2] == bk1_pkg::IDX_SLEEP_CONFIG) begin
        next_rdata = {16'h0000, sleep_word};
      end else begin
        next_rdata = 32'h00000000;
        next_rresp = bk1_pkg::RESP_SLVERR;
      end
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= 2'h0;
    end else begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

  // register fields; byte lane 1 holds slot and mode, lane 0 the voltage code
  always_comb begin
    next_wake_slot     = buck1_wake_slot;
    next_wake_opmode   = buck1_wake_opmode;
    next_wake_vcode_hi = wake_vcode_hi;
    next_wake_vcode_lo = wake_vcode_lo;
    next_sleep_slot    = buck1_sleep_slot;
    next_sleep_opmode  = buck1_sleep_opmode;
    next_sleep_vcode   = buck1_sleep_vcode;
    if (wr_wake && w_strb[1]) begin
      next_wake_slot   = w_data[bk1_pkg::SLOT_MSB:bk1_pkg::SLOT_LSB];
      next_wake_opmode = w_data[bk1_pkg::MODE_MSB:bk1_pkg::MODE_LSB];
    end
    if (wr_wake && w_strb[0]) begin
      next_wake_vcode_hi = w_data[bk1_pkg::VHI_MSB:bk1_pkg::VHI_LSB];
      next_wake_vcode_lo = w_data[bk1_pkg::VLO_MSB:bk1_pkg::VLO_LSB];
    end
    // boot load reaches only the upper five bits and beats a same-cycle write
    if (boot_load) begin
      next_wake_vcode_hi = boot_wake_vcode_hi;
    end
    if (wr_sleep && w_strb[1]) begin
      next_sleep_slot   = w_data[bk1_pkg::SLOT_MSB:bk1_pkg::SLOT_LSB];
      next_sleep_opmode = w_data[bk1_pkg::MODE_MSB:bk1_pkg::MODE_LSB];
    end
    if (wr_sleep && w_strb[0]) begin
      next_sleep_vcode = w_data[6:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      buck1_wake_slot    <= bk1_pkg::RST_WAKE_SLOT;
      buck1_wake_opmode  <= bk1_pkg::RST_WAKE_MODE;
      wake_vcode_hi      <= bk1_pkg::RST_WAKE_VHI;
      wake_vcode_lo      <= bk1_pkg::RST_WAKE_VLO;
      buck1_sleep_slot   <= bk1_pkg::RST_SLEEP_SLOT;
      buck1_sleep_opmode <= bk1_pkg::RST_SLEEP_MODE;
      buck1_sleep_vcode  <= bk1_pkg::RST_SLEEP_VCODE;
    end else begin
      buck1_wake_slot    <= next_wake_slot;
      buck1_wake_opmode  <= next_wake_opmode;
      wake_vcode_hi      <= next_wake_vcode_hi;
      wake_vcode_lo      <= next_wake_vcode_lo;
      buck1_sleep_slot   <= next_sleep_slot;
      buck1_sleep_opmode <= next_sleep_opmode;
      buck1_sleep_vcode  <= next_sleep_vcode;
    end
  end

  // slot decode; strobe bit n-1 stands for timeslot n
  always_comb begin
    wake_hit         = 1'b0;
    sleep_ts         = 3'h0;
    sleep_hit        = 1'b0;
    sleep_is_disable = 1'b0;
    if (buck1_wake_slot != bk1_pkg::SLOT_NONE && buck1_wake_slot <= bk1_pkg::SLOT_LAST) begin
      wake_hit = timeslot_strobe[buck1_wake_slot - 3'h1];
    end
    case (buck1_sleep_slot)
      3'h0: sleep_ts = 3'h5;
      3'h6: sleep_ts = 3'h3;
      3'h7: sleep_ts = 3'h1;
      default: begin
        sleep_ts         = 3'h6 - buck1_sleep_slot;
        sleep_is_disable = 1'b1;
      end
    endcase
    sleep_hit = timeslot_strobe[sleep_ts - 3'h1];
  end

  assign buck1_hw_controlled = (buck1_wake_slot == bk1_pkg::SLOT_HWEN1) ||
                               (buck1_wake_slot == bk1_pkg::SLOT_HWEN2);
  assign hw_level = (buck1_wake_slot == bk1_pkg::SLOT_HWEN1) ? hw_enable1 : hw_enable2;

  // converter state; sleep settings drop as soon as the wake state returns
  always_comb begin
    next_state = state;
    case (state)
      bk1_off: begin
        if (buck1_hw_controlled) begin
          if (hw_level) begin
            next_state = bk1_on;
          end
        end else if (!sleep_state && wake_hit) begin
          next_state = bk1_on;
        end
      end
      bk1_on: begin
        if (buck1_hw_controlled && !hw_level) begin
          next_state = bk1_off;
        end else if (sleep_state && sleep_hit) begin
          if (sleep_is_disable && !buck1_hw_controlled) begin
            next_state = bk1_off;
          end else begin
            next_state = bk1_on_sleep;
          end
        end
      end
      bk1_on_sleep: begin
        if (buck1_hw_controlled && !hw_level) begin
          next_state = bk1_off;
        end else if (!sleep_state) begin
          next_state = bk1_on;
        end
      end
      default: next_state = bk1_off;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= bk1_off;
    end else begin
      state <= next_state;
    end
  end

  // effective settings from the state being entered, so they settle with enable
  always_comb begin
    eff_vcode   = buck1_wake_vcode;
    next_opmode = buck1_wake_opmode;
    if (next_state == bk1_on_sleep) begin
      eff_vcode   = buck1_sleep_vcode;
      next_opmode = buck1_sleep_opmode;
    end
    // clamp both ends of the code range before scaling
    if (eff_vcode <= bk1_pkg::VCODE_FLOOR) begin
      vlevel = 7'h00;
    end else if (eff_vcode >= bk1_pkg::VCODE_CEIL) begin
      vlevel = bk1_pkg::VCODE_CEIL - bk1_pkg::VCODE_FLOOR;
    end else begin
      vlevel = eff_vcode - bk1_pkg::VCODE_FLOOR;
    end
    vout_wide = {15'h0000, vlevel} * {7'h00, bk1_pkg::VOUT_STEP_100UV};
    next_vout = bk1_pkg::VOUT_MIN_100UV + vout_wide[14:0];
  end

  // registered outputs toward the sequencer and analogue control
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      buck1_enable        <= 1'b0;
      buck1_sleep_applied <= 1'b0;
      buck1_opmode        <= bk1_pkg::RST_WAKE_MODE;
      buck1_vcode         <= 7'h00;
      buck1_vout_100uv    <= bk1_pkg::VOUT_MIN_100UV;
    end else begin
      buck1_enable        <= (next_state != bk1_off);
      buck1_sleep_applied <= (next_state == bk1_on_sleep);
      buck1_opmode        <= next_opmode;
      buck1_vcode         <= eff_vcode;
      buck1_vout_100uv    <= next_vout;
    end
  end

endmodule

// ### src/bk1_pkg.sv
// bk1_pkg: constants for the buck 1 wake/sleep configuration bank.
// assumes a 10 MHz system clock and a 32-bit AXI4-Lite register port.
package bk1_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [15:0] IDX_WAKE_CONFIG  = 16'h4058;
  localparam logic [15:0] IDX_SLEEP_CONFIG = 16'h4059;
  localparam int          ADDR_W           = 18;
  localparam logic [17:0] ADDR_WAKE_CONFIG  = {IDX_WAKE_CONFIG, 2'h0};
  localparam logic [17:0] ADDR_SLEEP_CONFIG = {IDX_SLEEP_CONFIG, 2'h0};

  // field positions, shared by both registers
  localparam int SLOT_LSB  = 13;
  localparam int SLOT_MSB  = 15;
  localparam int MODE_LSB  = 8;
  localparam int MODE_MSB  = 9;
  localparam int VHI_LSB   = 2;
  localparam int VHI_MSB   = 6;
  localparam int VLO_LSB   = 0;
  localparam int VLO_MSB   = 1;

  // values after reset
  localparam logic [2:0] RST_WAKE_SLOT   = 3'h0;
  localparam logic [1:0] RST_WAKE_MODE   = 2'h1;
  localparam logic [4:0] RST_WAKE_VHI    = 5'h00;
  localparam logic [1:0] RST_WAKE_VLO    = 2'h0;
  localparam logic [2:0] RST_SLEEP_SLOT  = 3'h0;
  localparam logic [1:0] RST_SLEEP_MODE  = 2'h3;
  localparam logic [6:0] RST_SLEEP_VCODE = 7'h00;

  // slot codes
  localparam logic [2:0] SLOT_NONE   = 3'h0;
  localparam logic [2:0] SLOT_LAST   = 3'h5;
  localparam logic [2:0] SLOT_HWEN1  = 3'h6;
  localparam logic [2:0] SLOT_HWEN2  = 3'h7;

  // operating modes
  typedef enum logic [1:0] {
    BK1_MODE_FCCM = 2'h0,
    BK1_MODE_AUTO = 2'h1,
    BK1_MODE_LDO  = 2'h2,
    BK1_MODE_HYST = 2'h3
  } bk1_opmode_t;

  // voltage mapping: codes up to 08h are 0.6 V, 68h and above 1.8 V
  localparam logic [6:0]  VCODE_FLOOR   = 7'h08;
  localparam logic [6:0]  VCODE_CEIL    = 7'h68;
  localparam logic [14:0] VOUT_MIN_100UV  = 15'h1770;  // 600.0 mV
  localparam logic [14:0] VOUT_STEP_100UV = 15'h007D;  // 12.5 mV
  localparam logic [6:0]  VCODE_4MHZ_MAX  = 7'h48;     // 1.4 V

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### testbench/bk1_config_checker.sv
// bk1_config_checker: concurrent checks on the buck 1 config bank ports.
// assumes it is bound onto bk1_config and that the bank has one clock domain.
`timescale 1ns/1ps

module bk1_config_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_bresp,
  // sequencer side
  input wire logic [4:0]  timeslot_strobe,
  input wire logic        sleep_state,
  input wire logic        hw_enable1,
  input wire logic        hw_enable2,
  // converter side
  input wire logic        buck1_enable,
  input wire logic        buck1_sleep_applied,
  input wire logic        buck1_hw_controlled,
  input wire logic [6:0]  buck1_vcode,
  input wire logic [14:0] buck1_vout_100uv
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // expected voltage in 0.1 mV; clamps both ends of the code range
  function automatic logic [14:0] vout_of(input logic [6:0] c);
    int k;
    k = (c < 7'h08) ? 8 : (c > 7'h68) ? 104 : int'(c);
    return 15'(6000 + 125 * (k - 8));
  endfunction

  // write accepted on both channels, then one hold cycle before the answer
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_hold_then_resp;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  a_write_resp_time: assert property (s_write_taken |=> s_hold_then_resp)
    else $error("write response not two cycles after accept");
  a_read_resp_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after accept");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_vout_map: assert property (buck1_vout_100uv == vout_of(buck1_vcode))
    else $error("output voltage does not match code");
  a_enable_cause: assert property ($rose(buck1_enable) |->
    $past(|timeslot_strobe || hw_enable1 || hw_enable2))
    else $error("converter enabled without strobe or hardware enable");
  a_disable_cause: assert property ($fell(buck1_enable) |->
    $past((sleep_state && |timeslot_strobe) || !(hw_enable1 && hw_enable2)))
    else $error("converter disabled without cause");
  a_hw_off: assert property (buck1_hw_controlled && !hw_enable1 && !hw_enable2 |=> !buck1_enable)
    else $error("hardware enable low but converter on");
  a_hw_on: assert property (buck1_hw_controlled && hw_enable1 && hw_enable2 |=> buck1_enable)
    else $error("hardware enable high but converter off");
  a_sleep_exit: assert property (!sleep_state |=> !buck1_sleep_applied)
    else $error("sleep settings kept in active state");
  a_sleep_entry: assert property ($rose(buck1_sleep_applied) |-> $past(sleep_state && |timeslot_strobe))
    else $error("sleep settings applied without sleep strobe");
endmodule

bind bk1_config bk1_config_checker i_chk (.*);

// ### testbench/bk1_config_tb.sv
// bk1_config_tb: self-checking bench for the buck 1 wake/sleep config bank.
// assumes bk1_pkg, bk1_config and the bound checker are compiled before it.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module bk1_config_tb;
  // design ports, named as the design names them
  logic        clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, buck1_opmode;
  logic        boot_load, sleep_state, hw_enable1, hw_enable2;
  logic [4:0]  boot_wake_vcode_hi, timeslot_strobe;
  logic        buck1_enable, buck1_sleep_applied, buck1_hw_controlled;
  logic [6:0]  buck1_vcode;
  logic [14:0] buck1_vout_100uv;
  // expectations and counters
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [33:0] er;
  logic [1:0]  eb;
  int          mismatches, checks;
  logic [31:0] seed = 32'hFFE82F9E;
  localparam logic [17:0] WK = bk1_pkg::ADDR_WAKE_CONFIG;
  localparam logic [17:0] SL = bk1_pkg::ADDR_SLEEP_CONFIG;
  localparam logic [1:0]  OK = bk1_pkg::RESP_OKAY;
  // wake boundary codes; 2 MHz switching assumed, so codes past 48h are legal
  logic [6:0]  cv [6] = '{7'h00, 7'h08, 7'h09, 7'h48, 7'h68, 7'h7F};
  // timeslot in which each sleep slot code acts
  int          tsl [8] = '{5, 5, 4, 3, 2, 1, 3, 1};

  bk1_config i_dut (.*);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [14:0] vx(input logic [6:0] c);
    int k;
    k = (c < 7'h08) ? 8 : (c > 7'h68) ? 104 : int'(c);
    return 15'(6000 + 125 * (k - 8));
  endfunction

  // one write; both channels offered together, bready held until the answer
  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    bq.push_back(r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) ad = 1'b1;
      if (s_axi_wready) dd = 1'b1;
      if (ad) s_axi_awvalid <= 1'b0;
      if (dd) s_axi_wvalid <= 1'b0;
    end while (!(ad && dd));
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [17:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // one-cycle strobe; outputs settle at the edge that samples it
  task automatic tick(input logic [4:0] st);
    @(posedge clk);
    timeslot_strobe <= st;
    @(posedge clk);
    timeslot_strobe <= 5'h00;
    @(negedge clk);
  endtask

  task automatic oc(input logic e, s, input logic [1:0] m, input logic [6:0] c);
    `CHK("enable", e, buck1_enable)
    `CHK("sleep", s, buck1_sleep_applied)
    `CHK("mode", m, buck1_opmode)
    `CHK("vcode", c, buck1_vcode)
    `CHK("vout", vx(c), buck1_vout_100uv)
  endtask

  // answer watcher: oldest note against each response as it appears
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
      er = rq.pop_front();
      `CHK("read", er, {s_axi_rresp, s_axi_rdata})
    end
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
      eb = bq.pop_front();
      `CHK("bresp", eb, s_axi_bresp)
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // watchdog: the whole run needs well under a millisecond
  initial begin
    #1000000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    logic [6:0] c, ws;
    logic [1:0] m, sel;
    logic [4:0] hi;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awprot, s_axi_arprot} = 6'h00;
    s_axi_wstrb = 4'hF;
    {boot_load, sleep_state, hw_enable1, hw_enable2} = 4'h0;
    {boot_wake_vcode_hi, timeslot_strobe} = 10'h000;
    rst_b = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    oc(1'b0, 1'b0, 2'h1, 7'h00);
    rd(WK, {OK, 32'h0000_0100});
    rd(SL, {OK, 32'h0000_0300});
    wr(18'h00000, 32'hFFFF_FFFF, bk1_pkg::RESP_SLVERR);
    rd(18'h00000, {bk1_pkg::RESP_SLVERR, 32'h0000_0000});
    // wake slots, modes and boundary codes
    for (int s = 0; s < 6; s++) begin
      c = cv[s];
      m = 2'(s);
      wr(SL, 32'h0000_2300, OK);
      wr(WK, {16'h0000, 3'(s), 3'h0, m, 1'b0, c}, OK);
      rd(WK, {OK, 16'h0000, 3'(s), 3'h0, m, 1'b0, c});
      tick(s == 5 ? 5'h01 : 5'(1 << s));
      `CHK("early", 1'b0, buck1_enable)
      tick(s == 0 ? 5'h10 : 5'(1 << (s - 1)));
      if (s != 0) oc(1'b1, 1'b0, m, c);
      else `CHK("never", 1'b0, buck1_enable)
      @(posedge clk);
      sleep_state <= 1'b1;
      tick(5'h10);
      `CHK("off", 1'b0, buck1_enable)
      @(posedge clk);
      sleep_state <= 1'b0;
    end
    // every sleep slot code, wrong timeslot first
    for (int t = 0; t < 8; t++) begin
      ws = 7'(rnd());
      c = 7'(rnd());
      m = 2'(t);
      wr(WK, {16'h0000, 3'h1, 5'h00, 1'b0, ws}, OK);
      wr(SL, {16'h0000, 3'(t), 3'h0, m, 1'b0, c}, OK);
      rd(SL, {OK, 16'h0000, 3'(t), 3'h0, m, 1'b0, c});
      tick(5'h01);
      oc(1'b1, 1'b0, 2'h0, ws);
      @(posedge clk);
      sleep_state <= 1'b1;
      tick(5'(1 << (tsl[t] % 5)));
      oc(1'b1, 1'b0, 2'h0, ws);
      tick(5'(1 << (tsl[t] - 1)));
      if (t >= 1 && t <= 5) `CHK("sleepoff", 1'b0, buck1_enable)
      else oc(1'b1, 1'b1, m, c);
      @(posedge clk);
      sleep_state <= 1'b0;
      tick(5'h00);
      if (t < 1 || t > 5) oc(1'b1, 1'b0, 2'h0, ws);
    end
    // hardware enable control, selected input only
    for (int h = 0; h < 2; h++) begin
      sel = 2'(1 << h);
      wr(SL, {16'h0000, 3'h2, 3'h0, 2'h2, 1'b0, 7'h30}, OK);
      wr(WK, {16'h0000, 3'(6 + h), 3'h0, 2'h0, 1'b0, 7'h20}, OK);
      `CHK("hwc", 1'b1, buck1_hw_controlled)
      @(posedge clk);
      {hw_enable2, hw_enable1} <= 2'h3;
      tick(5'h00);
      oc(1'b1, 1'b0, 2'h0, 7'h20);
      @(posedge clk);
      {hw_enable2, hw_enable1} <= ~sel;
      tick(5'h00);
      `CHK("hwsel", 1'b0, buck1_enable)
      @(posedge clk);
      {hw_enable2, hw_enable1} <= sel;
      sleep_state <= 1'b1;
      tick(5'h08);
      oc(1'b1, 1'b1, 2'h2, 7'h30);
      @(posedge clk);
      {hw_enable2, hw_enable1} <= 2'h0;
      sleep_state <= 1'b0;
      tick(5'h00);
      `CHK("hwlow", 1'b0, buck1_enable)
    end
    // boot store load touches only the upper five code bits
    wr(WK, 32'h0000_0103, OK);
    hi = 5'(rnd());
    @(posedge clk);
    boot_wake_vcode_hi <= hi;
    boot_load <= 1'b1;
    @(posedge clk);
    boot_load <= 1'b0;
    rd(WK, {OK, 16'h0000, 8'h01, 1'b0, hi, 2'h3});
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule
